/* File: design/pwl_defines.svh */
`ifndef PWL_DEFINES_SVH
`define PWL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PWL_OFS_MODE      8'h00
`define PWL_OFS_STATUS    8'h04
`define PWL_OFS_WORD      8'h08
`define PWL_OFS_P1CNT     8'h0c
`define PWL_OFS_P2CNT     8'h10

// ----------------------------------------------------------------------
// Pattern word field positions
// ----------------------------------------------------------------------
`define PWL_LINE0_LO_LSB  8
`define PWL_LINE0_HI_LSB  10
`define PWL_LINE1_P2_BIT  12
`define PWL_LINE1_P1_BIT  13
`define PWL_LINE2_P2_BIT  14

// ----------------------------------------------------------------------
// Mode register fields and reset values
// ----------------------------------------------------------------------
`define PWL_MODE_DFLT_BIT 0
`define PWL_MODE_EN_BIT   1
`define PWL_MODE_RST      2'h3
`define PWL_LINE_RST      1'h1
`define PWL_WORD_RST      32'h0000_0000

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define PWL_STAT_L0_BIT   0
`define PWL_STAT_L1_BIT   1
`define PWL_STAT_L2_BIT   2
`define PWL_STAT_RSVD_BIT 3
`define PWL_STAT_LOAD_BIT 4

`endif

/* File: design/pwl_pkg.sv */
package pwl_pkg;

	// ------------------------------------------------------------------
	// Two-bit level code of the line 0 phase fields
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PWL_CODE_DFLT = 2'b00,
		PWL_CODE_RSVD = 2'b01,
		PWL_CODE_LOW  = 2'b10,
		PWL_CODE_HIGH = 2'b11
	} pwl_code_t;

endpackage : pwl_pkg

/* File: design/pwl_edge_det.sv */
module pwl_edge_det #(
	parameter int unsigned WIDTH = 2
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	// Sampled levels
	input  wire logic [WIDTH-1:0] level_i,
	// Trailing edge pulses
	output logic      [WIDTH-1:0] fall_o
);

	logic [WIDTH-1:0] prev_q;
	logic [WIDTH-1:0] prev_d;

	// ------------------------------------------------------------------
	// Previous level
	// ------------------------------------------------------------------
	always_comb begin
		prev_d = level_i;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			prev_q <= '0;
		end else begin
			prev_q <= prev_d;
		end
	end

	// High last cycle, low now
	assign fall_o = prev_q & ~level_i;

endmodule : pwl_edge_det

/* File: design/pwl_decode_top.sv */
// Overview of operation
// - Line 0 high-phase code 10 drives line 0 low at phase one trailing edge.
// - Line 0 high-phase code 11 sets line 0 high at phase one trailing edge.
// - Line 0 high-phase code 00 takes line 0 level from mode default.
// - Bit 12 sets line 1 level at phase two trailing edge.
// - Bit 13 sets line 1 level at phase one trailing edge.
// - Bit 14 sets line 2 level at phase two trailing edge.
// - Line 0 low-phase code 10/11 drives line 0 low/high at phase two edge.
//
// Our own choices: the plain strobed port and the register addresses.

`include "pwl_defines.svh"

module pwl_decode_top
	import pwl_pkg::*;
#(
	parameter int unsigned ADDR_W = 8,
	parameter int unsigned CNT_W  = 16
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [31:0]       reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [31:0]       reg_rdata_o,
	// Pattern sequencer
	input  wire logic [31:0]       pat_word_i,
	input  wire logic              pat_valid_i,
	// Phase clocks
	input  wire logic              phase_clock_one_i,
	input  wire logic              phase_clock_two_i,
	// General lines
	output logic                   general_line_zero_n_o,
	output logic                   general_line_one_n_o,
	output logic                   general_line_two_n_o
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [1:0]        fall;
	logic [1:0]        ph_lvl;
	logic              p1_fall;
	logic              p2_fall;
	logic [31:0]       act_word;
	logic [1:0]        code_hi;
	logic [1:0]        code_lo;
	logic              upd_en;
	logic              dflt_lvl;
	logic              wr_mode;
	logic              wr_status;
	logic              wr_p1cnt;
	logic              wr_p2cnt;
	logic              rsvd_hit;

	logic [1:0]        mode_q;
	logic [1:0]        mode_d;
	logic [31:0]       word_q;
	logic [31:0]       word_d;
	logic              load_q;
	logic              load_d;
	logic              line0_q;
	logic              line0_d;
	logic              line1_q;
	logic              line1_d;
	logic              line2_q;
	logic              line2_d;
	logic              rsvd_q;
	logic              rsvd_d;
	logic [CNT_W-1:0]  p1cnt_q;
	logic [CNT_W-1:0]  p1cnt_d;
	logic [CNT_W-1:0]  p2cnt_q;
	logic [CNT_W-1:0]  p2cnt_d;
	logic [31:0]       rdata_q;
	logic [31:0]       rdata_d;
	logic [31:0]       rd_mux;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	// Level of line 0 for a phase field code; reserved code keeps it
	// 10 and 11 force a level, 00 takes the mode default
	function automatic logic pwl_line0_level(
		input logic [1:0] code,
		input logic       dflt,
		input logic       hold
	);
		logic lvl;
		lvl = hold;
		case (pwl_code_t'(code))
			PWL_CODE_LOW:  lvl = 1'b0;
			PWL_CODE_HIGH: lvl = 1'b1;
			PWL_CODE_DFLT: lvl = dflt;
			default:       lvl = hold;
		endcase
		return lvl;
	endfunction : pwl_line0_level

	// Edge counter; an edge in the clearing cycle is still counted
	function automatic logic [CNT_W-1:0] pwl_count(
		input logic [CNT_W-1:0] cur,
		input logic             ev,
		input logic             clr
	);
		logic [CNT_W-1:0] nxt;
		nxt = clr ? '0 : cur;
		if (ev) begin
			nxt = nxt + CNT_W'(1);
		end
		return nxt;
	endfunction : pwl_count

	// Register select for one offset of the map
	function automatic logic pwl_addr_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0]        ofs
	);
		return addr == ADDR_W'(ofs);
	endfunction : pwl_addr_hit

	// ------------------------------------------------------------------
	// Phase clock trailing edges
	// ------------------------------------------------------------------
	// Previous levels clear low, so a clock low at release gives no edge
	assign ph_lvl = {phase_clock_two_i, phase_clock_one_i};

	pwl_edge_det #(
		.WIDTH (2)
	) u_edge (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.level_i (ph_lvl),
		.fall_o  (fall)
	);

	// Bit 0 falls with phase one, bit 1 with phase two
	assign p1_fall = fall[0];
	assign p2_fall = fall[1];

	// ------------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------------
	// 0x00 mode: bit 0 default level of line 0, bit 1 update enable
	// 0x04 status: line levels, reserved-code flag, word loaded
	// 0x08 last word; 0x0c and 0x10 phase edge counts, cleared by any write
	assign wr_mode   = reg_wr_i && pwl_addr_hit(reg_addr_i, `PWL_OFS_MODE);
	assign wr_status = reg_wr_i && pwl_addr_hit(reg_addr_i, `PWL_OFS_STATUS);
	assign wr_p1cnt  = reg_wr_i && pwl_addr_hit(reg_addr_i, `PWL_OFS_P1CNT);
	assign wr_p2cnt  = reg_wr_i && pwl_addr_hit(reg_addr_i, `PWL_OFS_P2CNT);

	assign upd_en    = mode_q[`PWL_MODE_EN_BIT];
	assign dflt_lvl  = mode_q[`PWL_MODE_DFLT_BIT];

	// ------------------------------------------------------------------
	// Active pattern word
	// ------------------------------------------------------------------
	// A word offered in the edge cycle is used at once
	// The word then stands until the sequencer offers the next one
	assign act_word = pat_valid_i ? pat_word_i : word_q;
	assign code_hi  = act_word[`PWL_LINE0_HI_LSB +: 2];
	assign code_lo  = act_word[`PWL_LINE0_LO_LSB +: 2];

	always_comb begin
		word_d = word_q;
		load_d = load_q;
		if (pat_valid_i) begin
			word_d = pat_word_i;
			load_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			word_q <= `PWL_WORD_RST;
			load_q <= 1'b0;
		end else begin
			word_q <= word_d;
			load_q <= load_d;
		end
	end

	// ------------------------------------------------------------------
	// General line levels
	// ------------------------------------------------------------------
	// Phase two trails phase one within a pattern step, so it wins
	// Reserved code 01 keeps line 0 and only raises the status flag
	// With updates disabled all three lines are frozen
	always_comb begin
		line0_d = line0_q;
		line1_d = line1_q;
		line2_d = line2_q;
		if (upd_en && p1_fall) begin
			line0_d = pwl_line0_level(code_hi, dflt_lvl, line0_q);
			line1_d = act_word[`PWL_LINE1_P1_BIT];
		end
		if (upd_en && p2_fall) begin
			line0_d = pwl_line0_level(code_lo, dflt_lvl, line0_d);
			line1_d = act_word[`PWL_LINE1_P2_BIT];
			line2_d = act_word[`PWL_LINE2_P2_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			line0_q <= `PWL_LINE_RST;
			line1_q <= `PWL_LINE_RST;
			line2_q <= `PWL_LINE_RST;
		end else begin
			line0_q <= line0_d;
			line1_q <= line1_d;
			line2_q <= line2_d;
		end
	end

	assign general_line_zero_n_o = line0_q;
	assign general_line_one_n_o  = line1_q;
	assign general_line_two_n_o  = line2_q;

	// ------------------------------------------------------------------
	// Mode, status and counters
	// ------------------------------------------------------------------
	// Reserved code seen at an applied edge; write one to clear
	assign rsvd_hit = upd_en &&
		((p1_fall && (code_hi == PWL_CODE_RSVD)) ||
		 (p2_fall && (code_lo == PWL_CODE_RSVD)));

	always_comb begin
		mode_d = mode_q;
		if (wr_mode) begin
			mode_d = reg_wdata_i[1:0];
		end
		rsvd_d = rsvd_q;
		if (wr_status && reg_wdata_i[`PWL_STAT_RSVD_BIT]) begin
			rsvd_d = 1'b0;
		end
		// Set wins over a clear in the same cycle
		if (rsvd_hit) begin
			rsvd_d = 1'b1;
		end
		// Counters run even while line updates are frozen
		p1cnt_d = pwl_count(p1cnt_q, p1_fall, wr_p1cnt);
		p2cnt_d = pwl_count(p2cnt_q, p2_fall, wr_p2cnt);
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			mode_q  <= `PWL_MODE_RST;
			rsvd_q  <= 1'b0;
			p1cnt_q <= '0;
			p2cnt_q <= '0;
		end else begin
			mode_q  <= mode_d;
			rsvd_q  <= rsvd_d;
			p1cnt_q <= p1cnt_d;
			p2cnt_q <= p2cnt_d;
		end
	end

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (reg_addr_i)
			`PWL_OFS_MODE: begin
				rd_mux[1:0] = mode_q;
			end
			`PWL_OFS_STATUS: begin
				rd_mux[`PWL_STAT_L0_BIT]   = line0_q;
				rd_mux[`PWL_STAT_L1_BIT]   = line1_q;
				rd_mux[`PWL_STAT_L2_BIT]   = line2_q;
				rd_mux[`PWL_STAT_RSVD_BIT] = rsvd_q;
				rd_mux[`PWL_STAT_LOAD_BIT] = load_q;
			end
			`PWL_OFS_WORD: begin
				rd_mux = word_q;
			end
			`PWL_OFS_P1CNT: begin
				rd_mux[CNT_W-1:0] = p1cnt_q;
			end
			`PWL_OFS_P2CNT: begin
				rd_mux[CNT_W-1:0] = p2cnt_q;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
		// Zero outside the reply cycle
		rdata_d = reg_rd_i ? rd_mux : 32'h0000_0000;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

endmodule : pwl_decode_top

/* File: dv/pwl_decode_top_monitor.sv */
`include "pwl_defines.svh"

module pwl_decode_top_monitor #(
	parameter int unsigned ADDR_W = 8,
	parameter int unsigned CNT_W  = 16
) (
	// Clock, reset and register port
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [31:0]       reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [31:0]       reg_rdata_o,
	// Sequencer, phase clocks and lines
	input  wire logic [31:0]       pat_word_i,
	input  wire logic              pat_valid_i,
	input  wire logic              phase_clock_one_i,
	input  wire logic              phase_clock_two_i,
	input  wire logic              general_line_zero_n_o,
	input  wire logic              general_line_one_n_o,
	input  wire logic              general_line_two_n_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------------
	// Reference of active word, mode and trailing edges
	// ------------------------------------------------------------------
	logic [31:0] word_q;
	logic [31:0] act;
	logic        p1_q;
	logic        p2_q;
	logic        en_q;
	logic        dflt_q;
	logic        f1;
	logic        f2;

	always_comb begin
		act = pat_valid_i ? pat_word_i : word_q;
		f1  = p1_q && !phase_clock_one_i;
		f2  = p2_q && !phase_clock_two_i;
	end

	always_ff @(posedge clk_i) begin
		p1_q   <= !srst_i && phase_clock_one_i;
		p2_q   <= !srst_i && phase_clock_two_i;
		word_q <= srst_i ? 32'h0 : act;
		if (srst_i)
			{en_q, dflt_q} <= 2'h3;
		else if (reg_wr_i && reg_addr_i == `PWL_OFS_MODE)
			{en_q, dflt_q} <= reg_wdata_i[1:0];
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	sequence s_p1_only;
		f1 && !f2 && en_q;
	endsequence
	sequence s_p2;
		f2 && en_q;
	endsequence

	property p_l0_low;
		s_p1_only ##0 act[11:10] == 2'h2 |=> !general_line_zero_n_o;
	endproperty
	property p_l0_high;
		s_p1_only ##0 act[11:10] == 2'h3 |=> general_line_zero_n_o;
	endproperty
	property p_l0_dflt;
		s_p1_only ##0 act[11:10] == 2'h0
			|=> general_line_zero_n_o == $past(dflt_q);
	endproperty
	property p_l1_p2;
		s_p2 |=> general_line_one_n_o == $past(act[12]);
	endproperty
	property p_l1_p1;
		s_p1_only |=> general_line_one_n_o == $past(act[13]);
	endproperty
	property p_l2_p2;
		s_p2 |=> general_line_two_n_o == $past(act[14]);
	endproperty
	property p_l0_p2;
		s_p2 ##0 act[9] |=> general_line_zero_n_o == $past(act[8]);
	endproperty
	property p_hold;
		!(f1 || f2) || !en_q |=> $stable({general_line_two_n_o,
			general_line_one_n_o, general_line_zero_n_o});
	endproperty
	property p_rd_idle;
		!reg_rd_i |=> reg_rdata_o == 32'h0;
	endproperty

	a_l0_low: assert property (p_l0_low)
		else $error("line0 not low after code 10");
	a_l0_high: assert property (p_l0_high)
		else $error("line0 not high after code 11");
	a_l0_dflt: assert property (p_l0_dflt)
		else $error("line0 not at default level");
	a_l1_p2: assert property (p_l1_p2)
		else $error("line1 wrong after phase two edge");
	a_l1_p1: assert property (p_l1_p1)
		else $error("line1 wrong after phase one edge");
	a_l2_p2: assert property (p_l2_p2)
		else $error("line2 wrong after phase two edge");
	a_l0_p2: assert property (p_l0_p2)
		else $error("line0 wrong after phase two edge");
	a_hold: assert property (p_hold)
		else $error("line changed without an applied edge");
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside read reply");

endmodule : pwl_decode_top_monitor

bind pwl_decode_top pwl_decode_top_monitor #(
	.ADDR_W(ADDR_W),
	.CNT_W (CNT_W)
) u_mon (
	.clk_i                (clk_i),
	.srst_i               (srst_i),
	.reg_addr_i           (reg_addr_i),
	.reg_wdata_i          (reg_wdata_i),
	.reg_wr_i             (reg_wr_i),
	.reg_rd_i             (reg_rd_i),
	.reg_rdata_o          (reg_rdata_o),
	.pat_word_i           (pat_word_i),
	.pat_valid_i          (pat_valid_i),
	.phase_clock_one_i    (phase_clock_one_i),
	.phase_clock_two_i    (phase_clock_two_i),
	.general_line_zero_n_o(general_line_zero_n_o),
	.general_line_one_n_o (general_line_one_n_o),
	.general_line_two_n_o (general_line_two_n_o)
);

/* File: dv/pwl_line_sink.sv */
module pwl_line_sink (
	// Clock, line levels and sampled view
	input  wire logic       clk_i,
	input  wire logic [2:0] line_i,
	output logic      [2:0] seen_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Samples the control levels as the memory would at each clock
	always_ff @(posedge clk_i) begin
		seen_o <= line_i;
	end
endmodule : pwl_line_sink

/* File: dv/pattern_word_line_strobe_decode_test.sv */
`include "pwl_defines.svh"

module pattern_word_line_strobe_decode_test
	import pwl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, srst_i, reg_wr_i, reg_rd_i, pat_valid_i, ph1, ph2;
	logic [7:0]  reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, pat_word_i;
	wire  [2:0]  lines;
	logic [2:0]  seen;
	int          err_count, cmp_count;
	pwl_code_t   cd [4];
	logic        e  [4];

	pwl_decode_top uut (.clk_i(clk_i), .srst_i(srst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.pat_word_i(pat_word_i), .pat_valid_i(pat_valid_i),
		.phase_clock_one_i(ph1), .phase_clock_two_i(ph2),
		.general_line_zero_n_o(lines[0]), .general_line_one_n_o(lines[1]),
		.general_line_two_n_o(lines[2]));
	pwl_line_sink u_sink (.clk_i(clk_i), .line_i(lines), .seen_o(seen));

	initial begin
		clk_i = 1'h0;
		forever #50 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] s, x, input string n);
		cmp_count++;
		if (s !== x) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask : chk

	task automatic finish_test();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'h1;
		@(posedge clk_i);
		reg_wr_i    <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x,
			input string n);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'h1;
		@(posedge clk_i);
		reg_rd_i   <= 1'h0;
		#1;
		chk(reg_rdata_o, x, n);
	endtask : rd

	// Presents a word with the phase clocks selected by a and b high, then lets them fall
	task automatic ph(input logic [31:0] w, input logic a, input logic b);
		@(posedge clk_i);
		pat_word_i  <= w;
		pat_valid_i <= 1'h1;
		ph1         <= a;
		ph2         <= b;
		@(posedge clk_i);
		pat_valid_i <= 1'h0;
		ph1         <= 1'h0;
		ph2         <= 1'h0;
		@(posedge clk_i);
		#1;
	endtask : ph

	function automatic logic [31:0] mk(input pwl_code_t hi, input pwl_code_t lo,
			input logic b13, input logic b12, input logic b14);
		return {17'h0, b14, b13, b12, hi, lo, 8'h0};
	endfunction : mk

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial begin
		{srst_i, reg_wr_i, reg_rd_i, pat_valid_i, ph1, ph2} = 6'h20;
		reg_addr_i  = 8'h0;
		reg_wdata_i = 32'h0;
		pat_word_i  = 32'h0;
		err_count   = 0;
		cmp_count   = 0;
		cd = '{PWL_CODE_LOW, PWL_CODE_HIGH, PWL_CODE_DFLT, PWL_CODE_DFLT};
		e  = '{1'h0, 1'h1, 1'h0, 1'h1};
		repeat (12) @(posedge clk_i);
		srst_i <= 1'h0;
		rd(`PWL_OFS_MODE, 32'h3, "mode");
		rd(`PWL_OFS_STATUS, 32'h7, "status");
		rd(8'h40, 32'h0, "unmapped");
		for (int i = 0; i < 4; i++) begin
			wr(`PWL_OFS_MODE, (i == 2) ? 32'h2 : 32'h3);
			ph(mk(cd[i], PWL_CODE_DFLT, 1'h0, 1'h0, 1'h0), 1'h1, 1'h0);
			chk(lines[0], e[i], "line0 p1");
		end
		for (int b = 0; b < 2; b++) begin
			ph(mk(PWL_CODE_DFLT, PWL_CODE_DFLT, b[0], !b[0], !b[0]), 1'h1, 1'h0);
			chk(lines[1], b[0], "line1 p1");
			ph(mk(PWL_CODE_DFLT, cd[b], !b[0], b[0], b[0]), 1'h0, 1'h1);
			chk(lines, {3{b[0]}}, "lines p2");
		end
		ph(mk(PWL_CODE_HIGH, PWL_CODE_LOW, 1'h1, 1'h0, 1'h0), 1'h1, 1'h1);
		chk(lines, 3'h0, "both edges");
		repeat (5) @(posedge clk_i);
		#1;
		chk(lines, 3'h0, "hold");
		ph(mk(PWL_CODE_RSVD, PWL_CODE_RSVD, 1'h1, 1'h0, 1'h1), 1'h1, 1'h0);
		chk(lines, 3'h2, "reserved hold");
		rd(`PWL_OFS_STATUS, 32'h1a, "status flag");
		wr(`PWL_OFS_STATUS, 32'h8);
		rd(`PWL_OFS_STATUS, 32'h12, "status clear");
		wr(`PWL_OFS_MODE, 32'h1);
		ph(mk(PWL_CODE_HIGH, PWL_CODE_HIGH, 1'h0, 1'h1, 1'h1), 1'h1, 1'h1);
		chk(lines, 3'h2, "frozen");
		rd(`PWL_OFS_WORD,
			mk(PWL_CODE_HIGH, PWL_CODE_HIGH, 1'h0, 1'h1, 1'h1), "word");
		wr(`PWL_OFS_MODE, 32'h3);
		wr(`PWL_OFS_P1CNT, 32'h0);
		wr(`PWL_OFS_P2CNT, 32'h0);
		ph(mk(PWL_CODE_DFLT, PWL_CODE_DFLT, 1'h0, 1'h0, 1'h0), 1'h1, 1'h0);
		ph(mk(PWL_CODE_DFLT, PWL_CODE_DFLT, 1'h0, 1'h0, 1'h0), 1'h1, 1'h1);
		rd(`PWL_OFS_P1CNT, 32'h2, "p1 count");
		rd(`PWL_OFS_P2CNT, 32'h1, "p2 count");
		chk(seen, 3'h1, "sink view");
		ph(mk(PWL_CODE_LOW, PWL_CODE_RSVD, 1'h0, 1'h1, 1'h1), 1'h1, 1'h1);
		chk(lines, 3'h6, "reserved p2");
		rd(`PWL_OFS_STATUS, 32'h1e, "status p2 flag");
		@(posedge clk_i);
		srst_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		srst_i <= 1'h0;
		#1;
		chk(lines, 3'h7, "reset lines");
		rd(`PWL_OFS_MODE, 32'h3, "reset mode");
		rd(`PWL_OFS_STATUS, 32'h7, "reset status");
		rd(`PWL_OFS_P1CNT, 32'h0, "reset count");
		finish_test();
	end

	initial begin
		repeat (2000) @(posedge clk_i);
		err_count++;
		finish_test();
	end

endmodule : pattern_word_line_strobe_decode_test
